/* File: ifp_pkg.sv */
// package for the interrupt flag, enable and priority register block
// assumes a single 250 MHz clock domain and the plain strobe register port
package ifp_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int unsigned IFP_NSRC = 32;
	localparam int unsigned IFP_NPRI = 8;
	localparam int unsigned IFP_AW = 4;

	// ****************************************
	// register word offsets (word addresses, one 32-bit word each)
	// ****************************************
	localparam logic [IFP_AW-1:0] IFP_OFF_FLAG = 4'h0;
	localparam logic [IFP_AW-1:0] IFP_OFF_ENABLE = 4'h1;
	localparam logic [IFP_AW-1:0] IFP_OFF_PRIO0 = 4'h2;
	localparam logic [IFP_AW-1:0] IFP_OFF_PRIO_LAST = 4'h9;
	localparam logic [IFP_AW-1:0] IFP_OFF_IRQ_STAT = 4'hA;
	localparam logic [IFP_AW-1:0] IFP_OFF_IRQ_MASK = 4'hB;
	localparam logic [IFP_AW-1:0] IFP_OFF_ACTIVE = 4'hC;

	// ****************************************
	// reset values and field layout
	// ****************************************
	localparam logic [31:0] IFP_RST_WORD = 32'h0000_0000;
	localparam logic [31:0] IFP_PRIO_IMPL = 32'h1F1F_1F1F;
	localparam logic [2:0] IFP_PRIO_OFF = 3'h0;
	localparam int unsigned IFP_PRI_LSB = 2;
	localparam int unsigned IFP_SUB_LSB = 0;

	// interrupt status bits
	localparam int unsigned IFP_EV_NEWREQ = 0;
	localparam int unsigned IFP_EV_LOST = 1;
	localparam logic [1:0] IFP_EV_IMPL = 2'h3;

	// one slot of a priority word
	typedef struct packed {
		logic [2:0] pad;
		logic [2:0] prio;
		logic [1:0] sub;
	} ifp_slot_t;

	// register access request
	typedef struct packed {
		logic [IFP_AW-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} ifp_req_t;

	// best pending request offered to the core
	typedef struct packed {
		logic valid;
		logic [4:0] src;
		logic [2:0] prio;
		logic [1:0] sub;
	} ifp_pend_t;

endpackage

/* File: ifp_slot_reg.sv */
// one priority word: four slots of priority and subpriority
// assumes the parent decodes the word select and passes one write pulse
`timescale 1ns/10ps
module ifp_slot_reg (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// write side
	input wire logic we_i,
	input wire logic [31:0] wdata_i,
	// stored word, unimplemented bits zero
	output logic [31:0] word_o
);
	import ifp_pkg::*;

	// priority fields, subpriority fields, masked top bits
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			word_o <= IFP_RST_WORD;
		end else if (we_i) begin
			word_o <= wdata_i & IFP_PRIO_IMPL;
		end
	end

	chk_pad_bits_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(word_o & ~IFP_PRIO_IMPL) == 32'h0000_0000)
		else $error("unimplemented priority bits not zero");
endmodule

/* File: ifp_top.sv */
// interrupt flag, enable and priority register block with a pending picker
// assumes synchronous source request pulses and a strobe register master
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/10ps

// Contract
// - one flag per source in a word; set by a request, reads one until cleared
// - one enable bit per source; writing one enables, zero disables
// - three bit priority per source; zero keeps the source out of the picker, its flag and status event still set
// - two bit subpriority per source orders sources of equal priority
// - priority fields at bits 28:26, 20:18, 12:10, 4:2 for slots three to zero
// - subpriority fields at bits 25:24, 17:16, 9:8, 1:0
// - top three bits of every byte of a priority word ignore writes and read zero
module ifp_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// source requests, one cycle pulses
	input wire logic [ifp_pkg::IFP_NSRC-1:0] src_req_i,
	// register port
	input wire ifp_pkg::ifp_req_t bus_i,
	output logic [31:0] rdata_o,
	// towards the core
	output ifp_pkg::ifp_pend_t pend_o,
	output logic irq_o
);
	import ifp_pkg::*;

	// ****************************************
	// decode
	// ****************************************
	logic flag_we;
	logic en_we;
	logic stat_we;
	logic mask_we;
	logic [IFP_NPRI-1:0] prio_we;
	logic [31:0] prio_word [IFP_NPRI];
	logic [31:0] flag_q;
	logic [31:0] en_q;
	logic [1:0] stat_q;
	logic [1:0] mask_q;
	logic [1:0] ev_set;
	logic [4:0] prio_rel;

	assign flag_we = bus_i.wr && (bus_i.addr == IFP_OFF_FLAG);
	assign en_we = bus_i.wr && (bus_i.addr == IFP_OFF_ENABLE);
	assign stat_we = bus_i.wr && (bus_i.addr == IFP_OFF_IRQ_STAT);
	assign mask_we = bus_i.wr && (bus_i.addr == IFP_OFF_IRQ_MASK);
	// word index of a priority register relative to the first one
	assign prio_rel = {1'b0, bus_i.addr - IFP_OFF_PRIO0};

	// ****************************************
	// priority words
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < IFP_NPRI; g++) begin : g_prio
			// write pulse for this word only
			assign prio_we[g] = bus_i.wr && (bus_i.addr >= IFP_OFF_PRIO0) &&
				(bus_i.addr <= IFP_OFF_PRIO_LAST) && (prio_rel == 5'(g));
			ifp_slot_reg u_slot (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.we_i(prio_we[g]),
				.wdata_i(bus_i.wdata),
				.word_o(prio_word[g])
			);
		end
	endgenerate

	// ****************************************
	// flags and enables
	// ****************************************
	// flag latch; a request in the clearing cycle wins over the write
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_q <= IFP_RST_WORD;
		end else if (flag_we) begin
			flag_q <= bus_i.wdata | src_req_i;
		end else begin
			flag_q <= flag_q | src_req_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			en_q <= IFP_RST_WORD;
		end else if (en_we) begin
			en_q <= bus_i.wdata;
		end
	end

	// ****************************************
	// pending picker
	// ****************************************
	ifp_pend_t best;
	ifp_slot_t slot;
	logic live;

	// priority zero blocks; subpriority breaks ties, low index wins last
	always_comb begin
		best = '0;
		slot = '0;
		live = 1'b0;
		for (int i = 0; i < IFP_NSRC; i++) begin
			slot = ifp_slot_t'(prio_word[i/4][(i%4)*8 +: 8]);
			live = flag_q[i] && en_q[i] && (slot.prio != IFP_PRIO_OFF);
			if (live && (!best.valid || {slot.prio, slot.sub} > {best.prio, best.sub})) begin
				best.valid = 1'b1;
				best.src = 5'(i);
				best.prio = slot.prio;
				best.sub = slot.sub;
			end
		end
	end

	// registered offer to the core
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pend_o <= '0;
		end else begin
			pend_o <= best;
		end
	end

	// ****************************************
	// own event interrupt
	// ****************************************
	// a fresh request, and a request that hit an already set flag
	assign ev_set[IFP_EV_NEWREQ] = |(src_req_i & ~flag_q);
	assign ev_set[IFP_EV_LOST] = |(src_req_i & flag_q);

	// sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			stat_q <= 2'h0;
		end else if (stat_we) begin
			stat_q <= (stat_q & ~bus_i.wdata[1:0]) | ev_set;
		end else begin
			stat_q <= stat_q | ev_set;
		end
	end

	// mask register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mask_q <= 2'h0;
		end else if (mask_we) begin
			mask_q <= bus_i.wdata[1:0] & IFP_EV_IMPL;
		end
	end

	// level output from a flop; one cycle behind the status bits
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(stat_q & mask_q);
		end
	end

	// ****************************************
	// read port
	// ****************************************
	logic [31:0] rd_mux;

	// unmapped offsets read zero; read data stand for one cycle only
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (bus_i.addr == IFP_OFF_FLAG) begin
			rd_mux = flag_q;
		end else if (bus_i.addr == IFP_OFF_ENABLE) begin
			rd_mux = en_q;
		end else if (bus_i.addr >= IFP_OFF_PRIO0 && bus_i.addr <= IFP_OFF_PRIO_LAST) begin
			rd_mux = prio_word[prio_rel[2:0]];
		end else if (bus_i.addr == IFP_OFF_IRQ_STAT) begin
			rd_mux = {30'h0, stat_q};
		end else if (bus_i.addr == IFP_OFF_IRQ_MASK) begin
			rd_mux = {30'h0, mask_q};
		end else if (bus_i.addr == IFP_OFF_ACTIVE) begin
			rd_mux = 32'(best);
		end
	end

	// read data clear at reset like all state
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= IFP_RST_WORD;
		end else if (bus_i.rd) begin
			rdata_o <= rd_mux;
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	chk_flag_sets_on_req: assert property (@(posedge clk_i) disable iff (rst_i)
		src_req_i[0] |=> flag_q[0])
		else $error("flag did not set after request");
	chk_flag_holds_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		(flag_q[5] && !flag_we) |=> flag_q[5])
		else $error("flag dropped without a write");
	chk_enable_write: assert property (@(posedge clk_i) disable iff (rst_i)
		en_we |=> en_q == $past(bus_i.wdata))
		else $error("enable write not stored");
	chk_zero_prio_silent: assert property (@(posedge clk_i) disable iff (rst_i)
		(prio_word[0][4:2] == 3'h0 && prio_word[0][12:10] == 3'h0 &&
		prio_word[0][20:18] == 3'h0 && prio_word[0][28:26] == 3'h0) |->
		!(best.valid && best.src < 5'd4))
		else $error("priority zero source offered");
	chk_best_is_live: assert property (@(posedge clk_i) disable iff (rst_i)
		best.valid |-> (flag_q[best.src] && en_q[best.src] && best.prio != 3'h0))
		else $error("offered source not pending");
	chk_sub_orders_tie: assert property (@(posedge clk_i) disable iff (rst_i)
		(best.valid && best.src == 5'd1 && flag_q[0] && en_q[0] &&
		prio_word[0][4:2] == best.prio) |-> prio_word[0][1:0] < best.sub)
		else $error("subpriority order broken");
	chk_slot_fields: assert property (@(posedge clk_i) disable iff (rst_i)
		prio_we[0] |=> (prio_word[0][28:24] == $past(bus_i.wdata[28:24]) &&
		prio_word[0][4:0] == $past(bus_i.wdata[4:0])))
		else $error("priority field position wrong");
	chk_sub_fields: assert property (@(posedge clk_i) disable iff (rst_i)
		prio_we[1] |=> (prio_word[1][17:16] == $past(bus_i.wdata[17:16]) &&
		prio_word[1][9:8] == $past(bus_i.wdata[9:8])))
		else $error("subpriority field position wrong");
	chk_prio_read_pad: assert property (@(posedge clk_i) disable iff (rst_i)
		(bus_i.rd && bus_i.addr == IFP_OFF_PRIO0) |=> (rdata_o & 32'hE0E0_E0E0) == 32'h0)
		else $error("pad bits read nonzero");
	chk_reset_clear: assert property (@(posedge clk_i)
		$fell(rst_i) |-> (flag_q == 32'h0 && en_q == 32'h0 && prio_word[0] == 32'h0))
		else $error("state not cleared by reset");
	chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
		|(stat_q & mask_q) |=> irq_o)
		else $error("interrupt output missed");

	cov_pending_offer: cover property (@(posedge clk_i) disable iff (rst_i) best.valid ##1 pend_o.valid);
	cov_flag_clear: cover property (@(posedge clk_i) disable iff (rst_i) flag_q[0] ##1 !flag_q[0]);
	cov_lost_event: cover property (@(posedge clk_i) disable iff (rst_i) ev_set[IFP_EV_LOST]);
	cov_irq_raise: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
endmodule

/* File: ifp_core_model.sv */
// behavioural model of the core that takes the interrupt line and the pending offer
// assumes the block's clock and reset; it only watches, it never drives the block
`timescale 1ns/10ps
module ifp_core_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// from the block
	input wire ifp_pkg::ifp_pend_t pend_i,
	input wire logic irq_i,
	// rising edges of the interrupt line seen so far
	output logic [7:0] n_irq_o
);
	import ifp_pkg::*;
	logic irq_q;
	// count entries into service; a line that never drops counts once, like a real core
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_q <= 1'b0;
			n_irq_o <= 8'h00;
		end else begin
			irq_q <= irq_i;
			if (irq_i && !irq_q) begin
				n_irq_o <= n_irq_o + 8'h01;
			end
		end
	end
endmodule

/* File: testbench.sv */
// self-checking bench for the flag, enable and priority register block
// assumes the strobe register port of the design and a watching core model
`timescale 1ns/10ps
module testbench;
	import ifp_pkg::*;
	logic clk_i, rst_i;
	logic [31:0] src_req_i, rdata_o, wd, en_m, mask;
	ifp_req_t bus_i;
	ifp_pend_t pend_o, exp_p;
	logic irq_o;
	logic [7:0] n_irq, sl_m [32];
	int n_mismatch, num_checks, cycles, seed;
	ifp_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .src_req_i(src_req_i), .bus_i(bus_i),
		.rdata_o(rdata_o), .pend_o(pend_o), .irq_o(irq_o));
	ifp_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .pend_i(pend_o), .irq_i(irq_o),
		.n_irq_o(n_irq));
	// ****************************************
	// clock, timeout and helpers
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// about 1.9k cycles are needed; the ceiling leaves room without hiding a hang
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one strobe cycle then an idle cycle, so no signal is assigned twice per step
	task automatic wr(logic [IFP_AW-1:0] a, logic [31:0] d);
		@(posedge clk_i) bus_i <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_i) bus_i <= '0;
	endtask
	task automatic rd(logic [IFP_AW-1:0] a, output logic [31:0] d);
		@(posedge clk_i) bus_i <= '{a, 32'h0000_0000, 1'b0, 1'b1};
		@(posedge clk_i) bus_i <= '0;
		#1 d = rdata_o;
	endtask
	task automatic pulse(logic [31:0] m);
		@(posedge clk_i) src_req_i <= m;
		@(posedge clk_i) src_req_i <= '0;
	endtask
	// best source: highest priority then subpriority, ties to the lowest number
	function automatic ifp_pend_t pick(logic [31:0] fl, logic [31:0] en);
		ifp_pend_t b;
		b = '0;
		for (int i = 0; i < 32; i++) begin
			if (fl[i] && en[i] && sl_m[i][4:2] != 3'h0 && (!b.valid || sl_m[i][4:0] > {b.prio, b.sub})) begin
				b = '{1'b1, 5'(i), sl_m[i][4:2], sl_m[i][1:0]};
			end
		end
		return b;
	endfunction
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		logic [31:0] d;
		seed = 32'h644d7d90;
		rst_i = 1'b1;
		bus_i = '0;
		src_req_i = '0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		// every word, mapped or not, reads zero out of reset
		for (int a = 0; a < 16; a++) begin
			rd(4'(a), d);
			check("reset word", d, 32'h0000_0000);
		end
		wr(4'hD, $random(seed));
		rd(4'hD, d);
		check("unmapped", d, 32'h0000_0000);
		for (int it = 0; it < 40; it++) begin
			wr(IFP_OFF_FLAG, 32'h0000_0000);
			wr(IFP_OFF_IRQ_STAT, 32'h0000_0003);
			en_m = (it < 3) ? 32'hFFFF_FFFF : $random(seed);
			wr(IFP_OFF_ENABLE, en_m);
			rd(IFP_OFF_ENABLE, d);
			check("enable", d, en_m);
			// corners: all priorities zero, then all equal with pad bits set
			for (int k = 0; k < 8; k++) begin
				wd = (it == 1) ? 32'h0000_0000 : (it == 2) ? 32'hFFFF_FFFF : $random(seed);
				wr(IFP_OFF_PRIO0 + 4'(k), wd);
				for (int j = 0; j < 4; j++) sl_m[4*k+j] = wd[8*j+:8] & 8'h1F;
				rd(IFP_OFF_PRIO0 + 4'(k), d);
				check("priority word", d, wd & IFP_PRIO_IMPL);
			end
			mask = (it == 0) ? 32'h0000_0000 : (it < 3) ? 32'hFFFF_FFFF : $random(seed);
			pulse(mask);
			rd(IFP_OFF_FLAG, d);
			check("flags", d, mask);
			exp_p = pick(mask, en_m);
			check("pend valid", 32'(pend_o.valid), 32'(exp_p.valid));
			if (exp_p.valid) check("pend", 32'(pend_o), 32'(exp_p));
			rd(IFP_OFF_IRQ_STAT, d);
			check("status new", d, {31'h0, mask != 0});
		end
		// ****************************************
		// interrupt raise, mask and clear
		// ****************************************
		wr(IFP_OFF_FLAG, 32'h0000_0000);
		wr(IFP_OFF_IRQ_STAT, 32'h0000_0003);
		check("irq masked", 32'(irq_o), 32'h0);
		wr(IFP_OFF_IRQ_MASK, 32'h0000_0001);
		pulse(32'h0000_0010);
		repeat (2) @(posedge clk_i);
		check("irq raised", 32'(irq_o), 32'h1);
		pulse(32'h0000_0010);
		wr(IFP_OFF_IRQ_STAT, 32'h0000_0001);
		rd(IFP_OFF_IRQ_STAT, d);
		check("status lost", d, 32'h0000_0002);
		check("irq bit1 masked", 32'(irq_o), 32'h0);
		wr(IFP_OFF_IRQ_MASK, 32'h0000_0003);
		repeat (2) @(posedge clk_i);
		check("irq again", 32'(irq_o), 32'h1);
		wr(IFP_OFF_IRQ_STAT, 32'h0000_0002);
		repeat (2) @(posedge clk_i);
		check("irq cleared", 32'(irq_o), 32'h0);
		check("core entries", 32'(n_irq), 32'h2);
		report_and_stop();
	end
endmodule
